// File: rtl/frpc_ctrl.v
// Summary of operation
// [R1] Three rewrite modes: CPU commands, serial programmer, parallel programmer.
// [R2] Each program block 0..5 has a lock bit; locked blocks refuse program/erase.
// [R3] Data blocks A and B each have a protect bit in control one.
// [R4] Serial mode checks seven-byte ID unless reset vector bytes are all ones.
// [R5] ID mismatch makes the device refuse all later serial commands; the code lifts the refusal when a later ID check matches.
// [R6] Parallel protection active when override is 1 and select is 0.
// [R7] Parallel protection cleared only by erasing option block via CPU or serial.
// [R8] Erased option byte reads FFh, disabling all its protections and options.
// [R9] Detection level field: 00 3.80V, 01 2.85V, 10 2.35V, 11 1.90V.
// [R10] Software programs monitor start bit 0 to keep voltage resets active.
// [R11] Option bit 7 low enables source protection; bit 0 selects watchdog start.
// [R12] Software targets only user area blocks, never the boot area.
// [R13] During suspend, flash reads are serviced normally.
// [R14] Erase suspend accepts programs; program suspend does not.
// [R15] ROM-resident sub-mode holds the CPU for the whole program or erase.
// [R16] ROM-resident sub-mode refuses commands to blocks holding the running code.
// [R17] After program, erase or suspend entry, array returns to read mode.
// [R18] Suspend on enable and request both 1; ROM sub-mode only for data flash.
// [R19] Suspend also on enable plus interrupt bit and an enabled interrupt.
// [R20] Software polls ready, erase-error and program-error flags for outcome.
// [R21] Ready flag reads 0 during any operation, stop or activation, else 1.
// [R22] Program-error flag set when a program fails, else reads 0.
// [R23] Ready falls the cycle a command is taken, rises on finish or suspend.
`include "frpc_map.vh"
`default_nettype none
module frpc_ctrl (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Mode straps and external programmers
  input wire [1:0] rewrite_mode,
  input wire [55:0] serial_id_rx,
  input wire serial_id_valid,
  input wire [55:0] stored_id,
  input wire [23:0] reset_vector,
  input wire parallel_read_req,
  input wire parallel_write_req,
  // Flash array interface
  input wire [7:0] option_flash_byte,
  input wire op_fail,
  input wire [7:0] code_block_map,
  input wire irq_pending,
  // Outputs
  output reg cpu_hold,
  output reg array_read_mode,
  output reg serial_cmd_refused,
  output reg parallel_access_grant,
  output reg [7:0] option_function_select,
  output reg [1:0] detection_level,
  output reg monitor_reset_start,
  output reg source_protect_after_reset,
  output reg watchdog_autostart_select
);
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_PROG = 4'b0010;
  localparam [3:0] S_ERASE = 4'b0100;
  localparam [3:0] S_SUSP = 4'b1000;
  // Full-width copies so the timer load is cut on purpose
  localparam [31:0] PROG_CYC_W = `FRPC_PROG_CYC;
  localparam [31:0] ERASE_CYC_W = `FRPC_ERASE_CYC;

  ////////////////////////////////////////////////////////////////////////////
  reg [3:0] state_q;
  reg [15:0] timer_q;
  reg [15:0] saved_q;
  reg [2:0] blk_q;
  reg [2:0] sus_blk_q;
  reg sus_is_erase_q;
  reg [2:0] ctrl0_q;
  reg [1:0] ctrl1_q;
  reg [2:0] ctrl2_q;
  reg [5:0] lock_q;
  reg perr_q;
  reg eerr_q;
  reg id_bad_q;
  reg stop_busy_q;
  reg [7:0] option_q;
  reg loaded_q;
  wire opt_protect;
  wire [1:0] opt_level;
  wire opt_mon;
  wire opt_csp;
  wire opt_wdt;

  frpc_option_decode u_dec (
    .opt_byte(option_q),
    .parallel_protect(opt_protect),
    .detection_level(opt_level),
    .monitor_reset_start(opt_mon),
    .source_protect_after_reset(opt_csp),
    .watchdog_autostart_select(opt_wdt)
  );

  // Refusal test for one target block
  function blk_refused;
    input [2:0] blk;
    input [5:0] locks;
    input [1:0] dprot;
    input romres;
    input [7:0] code_map;
    begin
      if (blk == `FRPC_BLK_DATA_A) begin
        blk_refused = dprot[0]; // see [R3]
      end else if (blk == `FRPC_BLK_DATA_B) begin
        blk_refused = dprot[1]; // see [R3]
      end else begin
        blk_refused = locks[blk]; // see [R2]
      end
      if (romres && code_map[blk]) begin
        blk_refused = 1'b1; // see [R16]
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire wr = psel & penable & pwrite;
  wire rd = psel & penable & ~pwrite;
  wire id_skip = (reset_vector == 24'hFFFFFF);
  wire ready_flag = (state_q == S_IDLE || state_q == S_SUSP) && !stop_busy_q; // see [R21]
  wire cmd_wr = wr && paddr == `FRPC_ADDR_CMD;
  wire [1:0] cmd_op = pwdata[9:8];
  wire [2:0] cmd_blk = pwdata[2:0];
  wire serial_ok = rewrite_mode == `FRPC_MODE_SERIAL && !id_bad_q; // see [R5]
  wire cpu_ok = rewrite_mode == `FRPC_MODE_CPU && ctrl0_q[0];
  wire src_ok = cpu_ok || serial_ok; // see [R1]
  wire refused = blk_refused(cmd_blk, lock_q, ctrl1_q, ctrl0_q[1], code_block_map);
  wire start_prog = cmd_wr && src_ok && cmd_op == `FRPC_CMD_PROGRAM && !refused &&
    (state_q == S_IDLE || (state_q == S_SUSP && sus_is_erase_q)); // see [R14]
  wire start_erase = cmd_wr && src_ok && cmd_op == `FRPC_CMD_ERASE && !refused &&
    state_q == S_IDLE;
  wire resume = cmd_wr && src_ok && cmd_op == `FRPC_CMD_RESUME && state_q == S_SUSP;
  wire data_blk = blk_q == `FRPC_BLK_DATA_A || blk_q == `FRPC_BLK_DATA_B;
  wire sus_soft = ctrl2_q[0] && ctrl2_q[1] && (!ctrl0_q[1] || data_blk); // see [R18]
  wire sus_irq = ctrl2_q[0] && ctrl2_q[2] && irq_pending; // see [R19]
  wire busy_op = state_q == S_PROG || state_q == S_ERASE;
  wire do_suspend = busy_op && (sus_soft || sus_irq) && !(state_q == S_PROG && sus_is_erase_q);
  wire finishing = busy_op && timer_q == 16'h0001;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_IDLE;
      timer_q <= 16'h0000;
      saved_q <= 16'h0000;
      blk_q <= 3'h0;
      sus_blk_q <= 3'h0;
      sus_is_erase_q <= 1'b0;
      ctrl0_q <= 3'h0;
      ctrl1_q <= 2'h3;
      ctrl2_q <= 3'h0;
      lock_q <= 6'h3F;
      perr_q <= 1'b0;
      eerr_q <= 1'b0;
      id_bad_q <= 1'b0;
      stop_busy_q <= 1'b0;
      option_q <= `FRPC_OPTION_ERASED;
      loaded_q <= 1'b0;
    end else begin
      // Option byte copied once after reset release
      if (!loaded_q) begin
        option_q <= option_flash_byte;
        loaded_q <= 1'b1;
      end
      if (serial_id_valid && rewrite_mode == `FRPC_MODE_SERIAL && !id_skip) begin
        id_bad_q <= serial_id_rx != stored_id; // see [R4]
      end
      stop_busy_q <= 1'b0;
      if (wr) begin
        case (paddr)
          `FRPC_ADDR_CTRL0: begin
            ctrl0_q <= {pwdata[`FRPC_C0_STOP], pwdata[`FRPC_C0_ROMRES],
              pwdata[`FRPC_C0_ENABLE]};
            stop_busy_q <= pwdata[`FRPC_C0_STOP] != ctrl0_q[2]; // see [R21]
          end
          `FRPC_ADDR_CTRL1: ctrl1_q <= {pwdata[`FRPC_C1_DB_PROT], pwdata[`FRPC_C1_DA_PROT]};
          `FRPC_ADDR_CTRL2: ctrl2_q <= pwdata[2:0];
          `FRPC_ADDR_LOCK: if (state_q == S_IDLE) lock_q <= pwdata[5:0];
          default: begin
          end
        endcase
      end
      case (state_q)
        S_IDLE: begin
          if (start_prog) begin
            state_q <= S_PROG; // see [R23]
            timer_q <= PROG_CYC_W[15:0];
            blk_q <= cmd_blk;
            perr_q <= 1'b0;
            sus_is_erase_q <= 1'b0;
          end else if (start_erase) begin
            state_q <= S_ERASE; // see [R23]
            timer_q <= ERASE_CYC_W[15:0];
            blk_q <= cmd_blk;
            eerr_q <= 1'b0;
          end
        end
        S_PROG, S_ERASE: begin
          if (wr && paddr == `FRPC_ADDR_CTRL0 && pwdata[`FRPC_C0_ABORT]) begin
            state_q <= S_IDLE;
            // Abort drops any parked erase too, so no stale suspend flag survives
            sus_is_erase_q <= 1'b0;
          end else if (do_suspend) begin
            state_q <= S_SUSP; // see [R17]
            saved_q <= timer_q;
            sus_blk_q <= blk_q;
            sus_is_erase_q <= state_q == S_ERASE;
          end else if (finishing) begin
            if (state_q == S_PROG) begin
              perr_q <= op_fail; // see [R22]
              state_q <= sus_is_erase_q ? S_SUSP : S_IDLE; // see [R17]
            end else begin
              eerr_q <= op_fail;
              state_q <= S_IDLE;
              // An erase of the option block that does not fail brings back FFh, clearing all option protection
              if (blk_q == `FRPC_OPTION_BLK && !op_fail) begin
                option_q <= `FRPC_OPTION_ERASED; // see [R7] [R8]
              end
            end
            blk_q <= sus_blk_q;
          end else begin
            timer_q <= timer_q - 16'h0001;
          end
        end
        S_SUSP: begin
          if (start_prog) begin
            state_q <= S_PROG; // see [R14]
            timer_q <= PROG_CYC_W[15:0];
            blk_q <= cmd_blk;
            perr_q <= 1'b0;
          end else if (resume) begin
            state_q <= sus_is_erase_q ? S_ERASE : S_PROG;
            timer_q <= saved_q;
            blk_q <= sus_blk_q;
            if (!sus_is_erase_q) sus_is_erase_q <= 1'b0;
          end
          if (resume) ctrl2_q[1] <= 1'b0;
        end
        default: state_q <= S_IDLE;
      endcase
      if (state_q == S_SUSP && resume && sus_is_erase_q) sus_is_erase_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs, APB answers in the access cycle with no wait state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      cpu_hold <= 1'b0;
      array_read_mode <= 1'b1;
      serial_cmd_refused <= 1'b0;
      parallel_access_grant <= 1'b0;
      option_function_select <= 8'hFF;
      detection_level <= 2'h3;
      monitor_reset_start <= 1'b0;
      source_protect_after_reset <= 1'b0;
      watchdog_autostart_select <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `FRPC_ADDR_CTRL0: prdata <= {28'h0, ctrl0_q[2], ctrl0_q[1], ctrl0_q[0], 1'b0};
          `FRPC_ADDR_CTRL1: prdata <= {26'h0, ctrl1_q, 4'h0};
          `FRPC_ADDR_CTRL2: prdata <= {29'h0, ctrl2_q};
          `FRPC_ADDR_STATUS: prdata <= {24'h0, ready_flag, state_q == S_SUSP && sus_is_erase_q,
            eerr_q, perr_q, state_q == S_SUSP && !sus_is_erase_q, 3'h0}; // see [R20]
          `FRPC_ADDR_LOCK: prdata <= {26'h0, lock_q};
          `FRPC_ADDR_OPTION: prdata <= {24'h0, option_q};
          `FRPC_ADDR_IDCMP: prdata <= {31'h0, id_bad_q};
          `FRPC_ADDR_CMD: prdata <= {16'h0, timer_q};
          default: prdata <= 32'h00000000;
        endcase
      end
      if (psel && !penable) begin
        pslverr <= paddr > `FRPC_ADDR_PROG + 12'h004 || paddr[1:0] != 2'b00;
      end
      cpu_hold <= ctrl0_q[1] && (start_prog || start_erase ||
        (busy_op && !finishing && !do_suspend)); // see [R15]
      // Reads allowed whenever no operation is running, including suspend
      array_read_mode <= !(start_prog || start_erase || resume) &&
        (state_q == S_IDLE || state_q == S_SUSP || finishing || do_suspend); // see [R13] [R17]
      serial_cmd_refused <= rewrite_mode == `FRPC_MODE_SERIAL && id_bad_q; // see [R5]
      parallel_access_grant <= rewrite_mode == `FRPC_MODE_PARALLEL &&
        (parallel_read_req || parallel_write_req) && !opt_protect; // see [R6]
      option_function_select <= option_q;
      detection_level <= opt_level;
      monitor_reset_start <= opt_mon;
      source_protect_after_reset <= opt_csp;
      watchdog_autostart_select <= opt_wdt;
    end
  end
endmodule // frpc_ctrl
`default_nettype wire

// File: rtl/frpc_map.vh
`ifndef FRPC_MAP_VH
`define FRPC_MAP_VH
// APB byte offsets
`define FRPC_ADDR_CTRL0 12'h000
`define FRPC_ADDR_CTRL1 12'h004
`define FRPC_ADDR_CTRL2 12'h008
`define FRPC_ADDR_STATUS 12'h00C
`define FRPC_ADDR_CMD 12'h010
`define FRPC_ADDR_LOCK 12'h014
`define FRPC_ADDR_OPTION 12'h018
`define FRPC_ADDR_IDCMP 12'h01C
`define FRPC_ADDR_PROG 12'h020
// Option byte location within the flash
`define FRPC_OPTION_FLASH_ADDR 16'hFFFF
`define FRPC_OPTION_ERASED 8'hFF
// Option byte fields
`define FRPC_OPT_WDT 0
`define FRPC_OPT_OVR 2
`define FRPC_OPT_SEL 3
`define FRPC_OPT_LVL_LO 4
`define FRPC_OPT_LVL_HI 5
`define FRPC_OPT_MON 6
`define FRPC_OPT_CSP 7
// Control 0 fields
`define FRPC_C0_ENABLE 1
`define FRPC_C0_ROMRES 2
`define FRPC_C0_STOP 3
`define FRPC_C0_ABORT 4
// Control 1 fields
`define FRPC_C1_DA_PROT 4
`define FRPC_C1_DB_PROT 5
// Control 2 fields
`define FRPC_C2_SUS_EN 0
`define FRPC_C2_SUS_REQ 1
`define FRPC_C2_SUS_INT 2
// Status fields
`define FRPC_ST_PSUS 3
`define FRPC_ST_PERR 4
`define FRPC_ST_EERR 5
`define FRPC_ST_ESUS 6
`define FRPC_ST_READY 7
// Commands
`define FRPC_CMD_PROGRAM 2'h1
`define FRPC_CMD_ERASE 2'h2
`define FRPC_CMD_RESUME 2'h3
// Block numbering: 0..5 program, 6 = data A, 7 = data B
`define FRPC_BLK_DATA_A 3'h6
`define FRPC_BLK_DATA_B 3'h7
`define FRPC_OPTION_BLK 3'h5
// Rewrite modes
`define FRPC_MODE_CPU 2'h0
`define FRPC_MODE_SERIAL 2'h1
`define FRPC_MODE_PARALLEL 2'h2
// Operation times
`define FRPC_PROG_TIME_NS 1000
`define FRPC_ERASE_TIME_NS 20000
`define FRPC_CLK_NS 10
`define FRPC_PROG_CYC ((`FRPC_PROG_TIME_NS + `FRPC_CLK_NS - 1) / `FRPC_CLK_NS)
`define FRPC_ERASE_CYC ((`FRPC_ERASE_TIME_NS + `FRPC_CLK_NS - 1) / `FRPC_CLK_NS)
`endif

// File: rtl/frpc_option_decode.v
`include "frpc_map.vh"
`default_nettype none
module frpc_option_decode (
  // Option byte as held in flash
  input wire [7:0] opt_byte,
  // Decoded selections
  output wire parallel_protect,
  output wire [1:0] detection_level,
  output wire monitor_reset_start,
  output wire source_protect_after_reset,
  output wire watchdog_autostart_select
);
  // Override 1 with select 0 locks the parallel port
  assign parallel_protect = opt_byte[`FRPC_OPT_OVR] & ~opt_byte[`FRPC_OPT_SEL]; // see [R6]
  // 00=3.80V 01=2.85V 10=2.35V 11=1.90V, shared by monitor and power-on reset
  assign detection_level = {opt_byte[`FRPC_OPT_LVL_HI], opt_byte[`FRPC_OPT_LVL_LO]}; // see [R9]
  assign monitor_reset_start = ~opt_byte[`FRPC_OPT_MON];
  assign source_protect_after_reset = ~opt_byte[`FRPC_OPT_CSP]; // see [R11]
  assign watchdog_autostart_select = ~opt_byte[`FRPC_OPT_WDT]; // see [R11]
endmodule // frpc_option_decode
`default_nettype wire

// File: sim/frpc_ctrl_monitor.sv
`default_nettype none
module frpc_ctrl_monitor (
  // Clock, reset and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  // Straps and programmers
  input wire logic [1:0] rewrite_mode,
  input wire logic [55:0] serial_id_rx,
  input wire logic serial_id_valid,
  input wire logic [55:0] stored_id,
  input wire logic [23:0] reset_vector,
  input wire logic parallel_read_req,
  // Outputs watched
  input wire logic cpu_hold,
  input wire logic array_read_mode,
  input wire logic serial_cmd_refused,
  input wire logic parallel_access_grant,
  input wire logic [7:0] option_function_select,
  input wire logic [1:0] detection_level,
  input wire logic source_protect_after_reset,
  input wire logic watchdog_autostart_select
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  AST_APB_ACK: assert property (psel && !penable |=> pready)
    else $error("apb access not answered at once");
  AST_ID_SKIP: assert property (rewrite_mode == 2'h1 && serial_id_valid &&
    reset_vector == 24'hFFFFFF && !serial_cmd_refused |=> !serial_cmd_refused)
    else $error("id check not skipped on erased vector");
  AST_ID_REFUSE: assert property (rewrite_mode == 2'h1 && serial_id_valid &&
    reset_vector != 24'hFFFFFF && serial_id_rx != stored_id |-> ##[1:2] serial_cmd_refused)
    else $error("id mismatch not refused");
  AST_PAR_PROT: assert property (rewrite_mode == 2'h2 && parallel_read_req &&
    option_function_select[3:2] == 2'b01 |=> !parallel_access_grant)
    else $error("protected parallel access granted");
  AST_PAR_OPEN: assert property (rewrite_mode == 2'h2 && parallel_read_req &&
    option_function_select == 8'hFF |=> parallel_access_grant)
    else $error("erased option byte still protects");
  // Guarded by stable byte; decode and byte are registered on the same edge
  AST_LEVEL: assert property ($stable(option_function_select) |->
    detection_level == option_function_select[5:4])
    else $error("detection level wrong");
  AST_OPT_BITS: assert property ($stable(option_function_select) |->
    source_protect_after_reset == !option_function_select[7] &&
    watchdog_autostart_select == !option_function_select[0])
    else $error("option bit decode wrong");
  AST_HOLD: assert property ($rose(cpu_hold) |->
    $past(psel && penable && pwrite) ##1 cpu_hold [*8])
    else $error("cpu hold not tied to command");
  AST_READ_MODE: assert property ($fell(cpu_hold) |-> array_read_mode)
    else $error("array not in read mode after operation");
endmodule // frpc_ctrl_monitor
bind frpc_ctrl frpc_ctrl_monitor frpc_ctrl_monitor_inst (.pclk, .presetn, .psel, .penable,
  .pwrite, .pready, .rewrite_mode, .serial_id_rx, .serial_id_valid, .stored_id,
  .reset_vector, .parallel_read_req, .cpu_hold, .array_read_mode, .serial_cmd_refused,
  .parallel_access_grant, .option_function_select, .detection_level,
  .source_protect_after_reset, .watchdog_autostart_select);
`default_nettype wire

// File: sim/testbench.sv
`include "frpc_map.vh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] C0 = `FRPC_ADDR_CTRL0, C1 = `FRPC_ADDR_CTRL1, C2 = `FRPC_ADDR_CTRL2;
  localparam logic [11:0] ST = `FRPC_ADDR_STATUS, CMD = `FRPC_ADDR_CMD;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, serr;
  logic pready, pslverr, serial_id_valid = 0, parallel_read_req = 0, parallel_write_req = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [1:0] rewrite_mode = 0, detection_level;
  logic [55:0] serial_id_rx = 0, stored_id = 0;
  logic [23:0] reset_vector = 0;
  logic [7:0] option_flash_byte = 8'hFF, code_block_map = 0, opt, option_function_select;
  logic op_fail = 0, irq_pending = 0, cpu_hold, array_read_mode, serial_cmd_refused;
  logic parallel_access_grant, monitor_reset_start, source_protect_after_reset;
  logic watchdog_autostart_select;
  int fails = 0, n_tests = 0, seed = 32'h54EC35E4, i;
  frpc_ctrl frpc_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rewrite_mode, .serial_id_rx, .serial_id_valid, .stored_id,
    .reset_vector, .parallel_read_req, .parallel_write_req, .option_flash_byte, .op_fail,
    .code_block_map, .irq_pending, .cpu_hold, .array_read_mode, .serial_cmd_refused,
    .parallel_access_grant, .option_function_select, .detection_level,
    .monitor_reset_start, .source_protect_after_reset, .watchdog_autostart_select);
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 pclk = ~pclk;
  end
  task give_verdict;
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge pclk);
    fails++;
    give_verdict;
  end
  task check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", nm, e, g);
      fails++;
    end
  endtask
  // Parallel port is shut only by override 1 with select 0
  function automatic logic exp_grant(input logic [7:0] o);
    return !(o[`FRPC_OPT_OVR] && !o[`FRPC_OPT_SEL]);
  endfunction
  // Decoded option outputs are active high, stored bits active low
  function automatic logic exp_on(input logic [7:0] o, input int pos);
    return !o[pos];
  endfunction
  // Master samples pready before the edge's own updates land
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    serr = pslverr;
    psel <= 0;
    penable <= 0;
    check("pready", 1, pready);
  endtask
  task rdm(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(0, a, 0);
    check(nm, e, rd & m);
  endtask
  // Bounded poll, long enough for one full erase
  task wait_ready;
    int k;
    for (k = 0; k < 1500; k++) begin
      apb(0, ST, 0);
      if (rd[7] === 1'b1) break;
    end
    check("ready", 1, rd[7]);
  endtask
  task rst(input logic [7:0] o);
    option_flash_byte <= o;
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    repeat (3) @(posedge pclk);
  endtask
  task id_pulse;
    @(posedge pclk);
    serial_id_valid <= 1;
    @(posedge pclk);
    serial_id_valid <= 0;
    repeat (2) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    for (i = 0; i < 6; i++) begin
      opt = 8'($random(seed));
      opt[5:4] = i[1:0];
      if (i == 4) opt[3:2] = 2'b01;
      if (i == 5) opt = 8'hFF;
      rst(opt);
      check("level", opt[5:4], detection_level);
      check("csp", exp_on(opt, `FRPC_OPT_CSP), source_protect_after_reset);
      check("wdt", exp_on(opt, `FRPC_OPT_WDT), watchdog_autostart_select);
      check("mon", exp_on(opt, `FRPC_OPT_MON), monitor_reset_start);
      rdm("optreg", `FRPC_ADDR_OPTION, 32'hFF, opt);
      check("optserr", 0, serr);
      rewrite_mode <= `FRPC_MODE_PARALLEL;
      parallel_read_req <= 1;
      parallel_write_req <= i[0];
      repeat (2) @(posedge pclk);
      check("grant", exp_grant(opt), parallel_access_grant);
      rewrite_mode <= `FRPC_MODE_CPU;
      parallel_read_req <= 0;
      parallel_write_req <= 0;
    end
    rst(8'hF7);
    rdm("lock", `FRPC_ADDR_LOCK, 32'h3F, 32'h3F);
    rdm("dprot", C1, 32'h30, 32'h30);
    wr_seq_start: begin
      apb(1, C0, 32'h2);
      apb(1, CMD, 32'h100);
      rdm("locked", ST, 32'h80, 32'h80);
      apb(1, `FRPC_ADDR_LOCK, 0);
      op_fail <= 1;
      apb(1, CMD, 32'h101);
      rdm("busy", ST, 32'h80, 0);
      wait_ready;
      rdm("perr", ST, 32'h10, 32'h10);
      op_fail <= 0;
      apb(1, CMD, 32'h106);
      rdm("prot_a", ST, 32'h80, 32'h80);
      apb(1, C1, 32'h20);
      apb(1, CMD, 32'h107);
      rdm("prot_b", ST, 32'h80, 32'h80);
      apb(1, CMD, 32'h106);
      rdm("open_a", ST, 32'h80, 0);
      wait_ready;
      rdm("perr0", ST, 32'h10, 0);
    end
    apb(1, CMD, 32'h202);
    apb(1, C2, 32'h3);
    wait_ready;
    rdm("esus", ST, 32'hC0, 32'hC0);
    check("rmode", 1, array_read_mode);
    apb(1, CMD, 32'h103);
    rdm("prog_esus", ST, 32'h80, 0);
    wait_ready;
    rdm("back_esus", ST, 32'h40, 32'h40);
    apb(1, CMD, 32'h300);
    wait_ready;
    rdm("done", ST, 32'h68, 0);
    apb(1, CMD, 32'h104);
    apb(1, C2, 32'h3);
    wait_ready;
    rdm("psus", ST, 32'h08, 32'h08);
    apb(1, CMD, 32'h102);
    rdm("no_prog_psus", ST, 32'h88, 32'h88);
    apb(1, CMD, 32'h300);
    wait_ready;
    apb(1, C2, 32'h5);
    apb(1, CMD, 32'h203);
    irq_pending <= 1;
    wait_ready;
    rdm("irq_sus", ST, 32'h40, 32'h40);
    irq_pending <= 0;
    apb(1, C2, 0);
    apb(1, CMD, 32'h300);
    wait_ready;
    apb(1, CMD, 32'h205);
    wait_ready;
    repeat (2) @(posedge pclk);
    check("opt_erased", 8'hFF, option_function_select);
    code_block_map <= 8'h02;
    apb(1, C0, 32'h6);
    apb(1, CMD, 32'h101);
    rdm("own_blk", ST, 32'h80, 32'h80);
    apb(1, CMD, 32'h104);
    apb(1, C2, 32'h3);
    repeat (20) @(posedge pclk);
    check("hold", 1, cpu_hold);
    rdm("no_sus", ST, 32'h88, 0);
    wait_ready;
    check("hold_end", 0, cpu_hold);
    check("rmode2", 1, array_read_mode);
    apb(1, C2, 0);
    rewrite_mode <= `FRPC_MODE_SERIAL;
    stored_id <= 56'({$random(seed), $random(seed)});
    serial_id_rx <= 56'({$random(seed), $random(seed)});
    reset_vector <= 24'hFFFFFF;
    id_pulse;
    check("skip_id", 0, serial_cmd_refused);
    // Force a sure mismatch for the refusal case
    serial_id_rx <= ~stored_id;
    reset_vector <= 24'($random(seed)) & 24'hFFFFFE;
    id_pulse;
    check("refused", 1, serial_cmd_refused);
    rdm("idreg", `FRPC_ADDR_IDCMP, 32'h1, 32'h1);
    apb(1, CMD, 32'h203);
    rdm("cmd_refused", ST, 32'h80, 32'h80);
    apb(0, 12'h030, 0);
    check("slverr", 1, serr);
    give_verdict;
  end
endmodule // testbench
`default_nettype wire
